// ---- inc/fcs_pkg.sv ----
/*
  shared constants for the flash command/status host controller:
  register offsets, field positions, flash command codes, timing counts.
  assumes a 40 MHz system clock and a byte-wide asynchronous flash.
*/
package fcs_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int WAKE_TO_READ_NS = 600;   // wake_to_read_interval, plain default
  localparam int WAKE_TO_WRITE_NS = 1000; // wake_to_write_interval, plain default
  localparam int STROBE_NS = 100;         // width of the write strobe phase; read strobe adds two cycles
  localparam int WAKE_READ_CYC = (WAKE_TO_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_WRITE_CYC = (WAKE_TO_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;

  // ----------------------------------------------------------------
  // wishbone register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;   // write: go/op/powerdown
  localparam logic [3:0] REG_ADDR = 4'h4;   // flash address
  localparam logic [3:0] REG_DATA = 4'h8;   // write data / read data
  localparam logic [3:0] REG_STAT = 4'hc;   // controller status

  // ctrl fields
  localparam int CTRL_GO = 0;
  localparam int CTRL_OP_LO = 1;
  localparam int CTRL_PD = 4;
  // stat fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_RB = 1;
  localparam int STAT_AWAKE = 2;
  localparam int STAT_FLAGS_LO = 8;

  // operations the host can run
  localparam logic [2:0] OP_WRITE_CMD = 3'h0;  // one bus write of data to addr
  localparam logic [2:0] OP_READ = 3'h1;       // one bus read at addr
  localparam logic [2:0] OP_STATUS = 3'h2;     // read status register
  localparam logic [2:0] OP_READ_ARRAY = 3'h3; // issue read-array command

  // flash command codes
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;

  // status byte bit positions
  localparam int SR_READY = 7;
  localparam int SR_ERASE_SUSP = 6;
  localparam int SR_ERASE_ERR = 5;
  localparam int SR_WRITE_ERR = 4;
  localparam int SR_SUPPLY_ERR = 3;
  localparam int SR_WRITE_SUSP = 2;
  localparam int SR_PROTECT = 1;

  localparam int ADDR_W = 19;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

endpackage

// ---- logic/fcs_host.sv ----
/*
  host controller for a byte-wide asynchronous flash: runs single bus
  writes and reads, reads the status byte, manages powerdown_reset_n and
  the wake-up intervals. software reaches it over classic wishbone.
  assumes flash pins go through board buffers; data bus is tristated
  outside this module from the three-signal split.
*/
// Our own choices: the placing of the registers and the Wishbone register port.
// Notes on behaviour
// - lower status bits only trusted once the ready bit reads one
// - after an abort the host reissues the whole command sequence (this module does not: it returns to ST_IDLE and software starts again)
// - host issues read-array before reading the array after programming (left to software via OP_READ_ARRAY; OP_READ does not issue it)
// - writes taken only with write enable and chip enable both low
// - host waits wake intervals after raising reset before read or write
`timescale 1ns/10ps
module fcs_host (
  input wire logic clk_i,           // 40 MHz clock
  input wire logic rst_i,           // sync reset, active high
  // wishbone slave
  input wire logic wb_cyc_i,        // cycle
  input wire logic wb_stb_i,        // strobe
  input wire logic wb_we_i,         // write enable
  input wire logic [3:0] wb_adr_i,  // byte address
  input wire logic [3:0] wb_sel_i,  // byte selects
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o,     // read data
  output logic wb_ack_o,            // acknowledge
  // flash pins
  output logic [18:0] fl_addr_o,    // flash address
  input wire logic [7:0] fl_dq_i,   // data from flash
  output logic [7:0] fl_dq_o,       // data to flash
  output logic fl_dq_oe_o,          // high while host drives data
  output logic fl_ce_n_o,           // chip enable, active low
  output logic fl_we_n_o,           // write enable, active low
  output logic fl_oe_n_o,           // output enable, active low
  output logic powerdown_reset_n_o, // flash reset/power-down, active low
  input wire logic ready_busy_out_i // flash ready/busy, low busy
);

  // ----------------------------------------------------------------
  // pin input synchronisers
  // ----------------------------------------------------------------
  logic [7:0] dq_s1_r, dq_s2_r;
  logic rb_s1_r, rb_s2_r;
  // two flops on every input pin
  always_ff @(posedge clk_i)
  begin
    dq_s1_r <= fl_dq_i;
    dq_s2_r <= dq_s1_r;
    rb_s1_r <= ready_busy_out_i;
    rb_s2_r <= rb_s1_r;
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b00_0001,
    ST_SETUP = 6'b00_0010,
    ST_WSTB  = 6'b00_0100,
    ST_RSTB  = 6'b00_1000,
    ST_HOLD  = 6'b01_0000,
    ST_STAT  = 6'b10_0000
  } fcs_state_t;

  fcs_state_t state_r, state_nxt;
  logic [fcs_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  logic [fcs_pkg::CNT_W-1:0] wake_r, wake_nxt;
  logic [2:0] op_r, op_nxt;
  logic pd_r, pd_nxt;
  logic [18:0] addr_r, addr_nxt;
  logic [7:0] wdata_r, wdata_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [7:0] flags_r, flags_nxt;
  logic [7:0] drive_r, drive_nxt;
  logic ce_n_r, ce_n_nxt, we_n_r, we_n_nxt, oe_n_r, oe_n_nxt, dq_oe_r, dq_oe_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic wb_req, go;
  logic read_ok, write_ok;

  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_r;
  assign go = wb_req & wb_we_i & (wb_adr_i == fcs_pkg::REG_CTRL) & wb_sel_i[0]
              & wb_dat_i[fcs_pkg::CTRL_GO] & (state_r == ST_IDLE);
  // one wake counter gates reads and writes after the reset pin rises
  assign read_ok = pd_r & (wake_r >= fcs_pkg::CNT_W'(fcs_pkg::WAKE_READ_CYC));
  assign write_ok = pd_r & (wake_r >= fcs_pkg::CNT_W'(fcs_pkg::WAKE_WRITE_CYC));

  // next-state and bus logic
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    op_nxt = op_r;
    pd_nxt = pd_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    rdata_nxt = rdata_r;
    flags_nxt = flags_r;
    drive_nxt = drive_r;
    ce_n_nxt = ce_n_r;
    we_n_nxt = we_n_r;
    oe_n_nxt = oe_n_r;
    dq_oe_nxt = dq_oe_r;
    ack_nxt = wb_req;
    rd_nxt = rd_r;
    wake_nxt = wake_r;
    // wake counter runs while reset pin is high, saturating
    if (!pd_r)
      wake_nxt = '0;
    else if (wake_r != '1)
      wake_nxt = wake_r + 1'b1;
    // register writes
    if (wb_req && wb_we_i)
    begin
      if (wb_adr_i == fcs_pkg::REG_ADDR)
        addr_nxt = wb_dat_i[18:0];
      if (wb_adr_i == fcs_pkg::REG_DATA && wb_sel_i[0])
        wdata_nxt = wb_dat_i[7:0];
      // power-down is taken in any state so it can cut an access short
      if (wb_adr_i == fcs_pkg::REG_CTRL && wb_sel_i[0])
      begin
        pd_nxt = ~wb_dat_i[fcs_pkg::CTRL_PD];
        if (state_r == ST_IDLE)
          op_nxt = wb_dat_i[fcs_pkg::CTRL_OP_LO +: 3];
      end
    end
    // register reads
    if (wb_req && !wb_we_i)
    begin
      case (wb_adr_i)
        fcs_pkg::REG_CTRL: rd_nxt = {27'h000_0000, ~pd_r, 4'h0};
        fcs_pkg::REG_ADDR: rd_nxt = {13'h0000, addr_r};
        fcs_pkg::REG_DATA: rd_nxt = {24'h00_0000, rdata_r};
        fcs_pkg::REG_STAT: rd_nxt = {16'h0000, flags_r, 5'h00, read_ok, rb_s2_r,
                                      state_r != ST_IDLE};
        default: rd_nxt = fcs_pkg::RESET_WORD;
      endcase
    end
    case (state_r)
      ST_IDLE:
      begin
        // go refused while asleep or not yet awake; reads need only read wake
        if (go && (write_ok || (wb_dat_i[fcs_pkg::CTRL_OP_LO +: 3] == fcs_pkg::OP_READ
            && read_ok)))
        begin
          op_nxt = wb_dat_i[fcs_pkg::CTRL_OP_LO +: 3];
          state_nxt = ST_SETUP;
          cnt_nxt = '0;
          ce_n_nxt = 1'b0;
          case (wb_dat_i[fcs_pkg::CTRL_OP_LO +: 3])
            fcs_pkg::OP_WRITE_CMD: drive_nxt = wdata_r;
            fcs_pkg::OP_STATUS: drive_nxt = fcs_pkg::CMD_READ_STATUS;
            fcs_pkg::OP_READ_ARRAY: drive_nxt = fcs_pkg::CMD_READ_ARRAY;
            default: drive_nxt = drive_r;
          endcase
          dq_oe_nxt = (wb_dat_i[fcs_pkg::CTRL_OP_LO +: 3] != fcs_pkg::OP_READ);
        end
      end
      ST_SETUP:
      begin
        if (op_r == fcs_pkg::OP_READ)
        begin
          oe_n_nxt = 1'b0;
          state_nxt = ST_RSTB;
        end
        else
        begin
          we_n_nxt = 1'b0;
          state_nxt = ST_WSTB;
        end
      end
      ST_WSTB:
      begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == fcs_pkg::CNT_W'(fcs_pkg::STROBE_CYC - 1))
        begin
          we_n_nxt = 1'b1; // command latched on rising write enable
          cnt_nxt = '0;
          state_nxt = ST_HOLD;
        end
      end
      ST_RSTB:
      begin
        cnt_nxt = cnt_r + 1'b1;
        // wait strobe width plus two sync stages before sampling
        if (cnt_r == fcs_pkg::CNT_W'(fcs_pkg::STROBE_CYC + 1))
        begin
          if (op_r == fcs_pkg::OP_STATUS)
            flags_nxt = dq_s2_r[fcs_pkg::SR_READY] ? dq_s2_r : 8'h00;
          else
            rdata_nxt = dq_s2_r;
          oe_n_nxt = 1'b1;
          ce_n_nxt = 1'b1;
          state_nxt = ST_IDLE;
        end
      end
      ST_HOLD:
      begin
        dq_oe_nxt = 1'b0;
        ce_n_nxt = 1'b1;
        if (op_r == fcs_pkg::OP_STATUS)
          state_nxt = ST_STAT;
        else
          state_nxt = ST_IDLE;
      end
      ST_STAT:
      begin
        // read phase of the status op: flash drives the status byte
        ce_n_nxt = 1'b0;
        oe_n_nxt = 1'b0;
        cnt_nxt = '0;
        state_nxt = ST_RSTB;
      end
      default: state_nxt = ST_IDLE;
    endcase
    // powering down mid-operation abandons the access
    if (!pd_nxt)
    begin
      state_nxt = ST_IDLE;
      flags_nxt = 8'h00;
      ce_n_nxt = 1'b1;
      we_n_nxt = 1'b1;
      oe_n_nxt = 1'b1;
      dq_oe_nxt = 1'b0;
    end
  end

  // state registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
      wake_r <= '0;
      op_r <= 3'h0;
      pd_r <= 1'b0;
      addr_r <= 19'h0_0000;
      wdata_r <= 8'h00;
      rdata_r <= 8'h00;
      flags_r <= 8'h00;
      drive_r <= 8'h00;
      ce_n_r <= 1'b1;
      we_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      dq_oe_r <= 1'b0;
      ack_r <= 1'b0;
      rd_r <= fcs_pkg::RESET_WORD;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      wake_r <= wake_nxt;
      op_r <= op_nxt;
      pd_r <= pd_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      rdata_r <= rdata_nxt;
      flags_r <= flags_nxt;
      drive_r <= drive_nxt;
      ce_n_r <= ce_n_nxt;
      we_n_r <= we_n_nxt;
      oe_n_r <= oe_n_nxt;
      dq_oe_r <= dq_oe_nxt;
      ack_r <= ack_nxt;
      rd_r <= rd_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rd_r;
  assign fl_addr_o = addr_r;
  assign fl_dq_o = drive_r;
  assign fl_dq_oe_o = dq_oe_r;
  assign fl_ce_n_o = ce_n_r;
  assign fl_we_n_o = we_n_r;
  assign fl_oe_n_o = oe_n_r;
  assign powerdown_reset_n_o = pd_r;

endmodule

// ---- dv/fcs_flash_model.sv ----
/* behavioural byte-wide flash: command latch, status byte, ready/busy.
   assumes the bench resolves the shared data wire. */
`timescale 1ns/10ps
module fcs_flash_model (
  input wire logic clk_i,         // bench clock, times operations
  input wire logic [18:0] addr_i, // address
  input wire logic [7:0] dq_i,    // data wire level
  output logic [7:0] dq_o,        // data from flash
  input wire logic ce_n_i,        // chip enable
  input wire logic we_n_i,        // write enable
  input wire logic oe_n_i,        // output enable
  input wire logic pd_n_i,        // power-down/reset
  input wire logic [7:0] err_i,   // flags of the next operation
  output logic rb_o               // ready/busy
);
  logic [7:0] flags_r = 8'h00, last_r = 8'h00, val;
  logic sts_r = 1'b0, we_q = 1'b1, drv;
  int busy_r = 0;
  // array byte or status byte; lower flags are noise while busy
  assign val = !sts_r ? addr_i[7:0] : (busy_r != 0 ? 8'h55 : {1'b1, flags_r[6:0]});
  assign rb_o = (busy_r == 0);
  // only a selected awake flash drives, else the wire shows noise
  assign drv = !ce_n_i && !oe_n_i && pd_n_i;
  assign dq_o = drv ? val : ~last_r;
  // command latch and internal operation
  always @(posedge clk_i)
  begin
    we_q <= we_n_i;
    if (drv)
      last_r <= val;
    if (!pd_n_i)
    begin
      flags_r <= 8'h00;
      sts_r <= 1'b0;
      busy_r <= 0;
    end
    else
    begin
      if (we_n_i && !we_q && !ce_n_i)
      begin
        sts_r <= (dq_i == 8'h70 || dq_i == 8'h20) ? 1'b1 : (dq_i == 8'hff ? 1'b0 : sts_r);
        if (dq_i == 8'h20 && busy_r == 0)
          busy_r <= 100;
      end
      if (busy_r != 0)
        busy_r <= busy_r - 1;
      if (busy_r == 1)
        flags_r <= err_i & 8'h7e;
    end
  end
endmodule

// ---- dv/fcs_host_props.sv ----
/* concurrent checks on fcs_host pins.
   assumes fcs_pkg is compiled first. */
`timescale 1ns/10ps
module fcs_host_props (
  input wire logic clk_i,              // clock
  input wire logic rst_i,              // sync reset
  input wire logic wb_cyc_i,           // cycle
  input wire logic wb_stb_i,           // strobe
  input wire logic wb_ack_o,           // ack
  input wire logic fl_dq_oe_o,         // host drives data
  input wire logic fl_ce_n_o,          // chip enable
  input wire logic fl_we_n_o,          // write enable
  input wire logic fl_oe_n_o,          // output enable
  input wire logic powerdown_reset_n_o // power-down
);
  logic [7:0] awake_r, awake_nxt;
  // cycles since power-down was lifted, saturating
  always_comb
    awake_nxt = (rst_i || !powerdown_reset_n_o) ? 8'h00 : awake_r + {7'h00, awake_r != 8'hff};
  always_ff @(posedge clk_i)
    awake_r <= awake_nxt;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held too long");
  property p_ack_ans; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_ans: assert property (p_ack_ans) else $error("request not acked");
  property p_we_ce; !fl_we_n_o |-> !fl_ce_n_o; endproperty
  a_we_ce: assert property (p_we_ce) else $error("write strobe without chip enable");
  property p_we_w; $fell(fl_we_n_o) |-> !fl_we_n_o [*4] ##1 fl_we_n_o; endproperty
  a_we_w: assert property (p_we_w) else $error("write strobe width");
  property p_oe; !fl_oe_n_o |-> !fl_dq_oe_o && !fl_ce_n_o; endproperty
  a_oe: assert property (p_oe) else $error("data contention");
  property p_pd; !powerdown_reset_n_o [*2] |-> fl_ce_n_o && fl_we_n_o; endproperty
  a_pd: assert property (p_pd) else $error("access in power-down");
  property p_wk_w; !fl_we_n_o |-> awake_r >= fcs_pkg::WAKE_WRITE_CYC; endproperty
  a_wk_w: assert property (p_wk_w) else $error("write too soon after wake");
  property p_wk_r; !fl_oe_n_o |-> awake_r >= fcs_pkg::WAKE_READ_CYC; endproperty
  a_wk_r: assert property (p_wk_r) else $error("read too soon after wake");
endmodule
bind fcs_host fcs_host_props i_fcs_host_props (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .fl_dq_oe_o(fl_dq_oe_o),
  .fl_ce_n_o(fl_ce_n_o), .fl_we_n_o(fl_we_n_o), .fl_oe_n_o(fl_oe_n_o),
  .powerdown_reset_n_o(powerdown_reset_n_o));

// ---- dv/fcs_host_tb.sv ----
/* bench for fcs_host against a behavioural flash.
   assumes fcs_pkg, fcs_host and fcs_flash_model compiled first. */
`timescale 1ns/10ps
module fcs_host_tb;
  localparam logic [31:0] Z = 32'h0000_0000;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic ce_n, we_n, oe_n, pd_n, dq_oe, ack, rb;
  logic [3:0] adr = 4'h0;
  logic [31:0] dat = Z, q, wq;
  logic [7:0] err = 8'h00, dh, df, dw;
  logic [18:0] fa;
  logic [7:0] errs [7] = '{8'h00, 8'h40, 8'h20, 8'h10, 8'h28, 8'h18, 8'h06};
  int mismatches = 0, samples_checked = 0;
  // data wire level: host data while dq_oe is high, else flash output
  assign dw = dq_oe ? dh : df;
  fcs_host i_fcs_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(wq),
    .wb_ack_o(ack), .fl_addr_o(fa), .fl_dq_i(dw), .fl_dq_o(dh), .fl_dq_oe_o(dq_oe),
    .fl_ce_n_o(ce_n), .fl_we_n_o(we_n), .fl_oe_n_o(oe_n), .powerdown_reset_n_o(pd_n),
    .ready_busy_out_i(rb));
  fcs_flash_model i_fcs_flash_model (.clk_i(clk_i), .addr_i(fa), .dq_i(dw), .dq_o(df),
    .ce_n_i(ce_n), .we_n_i(we_n), .oe_n_i(oe_n), .pd_n_i(pd_n), .err_i(err), .rb_o(rb));
  // 40 MHz clock
  initial forever #12.5 clk_i = ~clk_i;
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic tmo();
    mismatches++;
    $display("unexpected wait: expected done seen timeout");
    end_sim();
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", s, e, g);
    end
  endtask
  // one classic wishbone cycle, held until ack
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk_i) n++; while (ack !== 1'b1 && n < 64);
    q = wq;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 64)
      tmo();
  endtask
  // poll a status bit until it reads v
  task automatic wait_st(input int b, input logic v);
    int n;
    n = 0;
    wb(1'b0, fcs_pkg::REG_STAT, Z);
    while (q[b] !== v && n < 200)
    begin
      n++;
      wb(1'b0, fcs_pkg::REG_STAT, Z);
    end
    if (q[b] !== v)
      tmo();
  endtask
  task automatic op(input logic [2:0] c);
    wb(1'b1, fcs_pkg::REG_CTRL, {28'h000_0000, c, 1'b1});
    wait_st(fcs_pkg::STAT_BUSY, 1'b0);
  endtask
  task automatic flags(input logic [7:0] e, input logic [7:0] m);
    op(fcs_pkg::OP_STATUS);
    wb(1'b0, fcs_pkg::REG_STAT, Z);
    chk("status byte", {24'h00_0000, e}, {24'h00_0000, q[15:8] & m});
  endtask
  task automatic rd_arr(input logic [18:0] a);
    wb(1'b1, fcs_pkg::REG_ADDR, {13'h0000, a});
    op(fcs_pkg::OP_READ);
    wb(1'b0, fcs_pkg::REG_DATA, Z);
    chk("array byte", {24'h00_0000, a[7:0]}, {24'h00_0000, q[7:0]});
  endtask
  task automatic busy();
    wb(1'b1, fcs_pkg::REG_DATA, 32'h0000_0020);
    op(fcs_pkg::OP_WRITE_CMD);
  endtask
  // main sequence
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, fcs_pkg::REG_STAT, Z);
    chk("stat", 32'h0000_0002, q);
    wb(1'b1, fcs_pkg::REG_CTRL, Z);
    wait_st(fcs_pkg::STAT_AWAKE, 1'b1);
    rd_arr(19'h0_00a5);
    flags(8'h80, 8'hff);
    $display("test wake done");
    foreach (errs[i])
    begin
      err <= errs[i];
      busy();
      wb(1'b0, fcs_pkg::REG_STAT, Z);
      chk("ready busy", Z, {31'h0000_0000, q[fcs_pkg::STAT_RB]});
      flags(8'h00, 8'hff);
      wait_st(fcs_pkg::STAT_RB, 1'b1);
      flags(8'h80 | errs[i], 8'hff);
    end
    $display("test flags done");
    err <= 8'h10;
    busy();
    // power-down lands while a read access is still running
    wb(1'b1, fcs_pkg::REG_CTRL, {28'h000_0000, fcs_pkg::OP_READ, 1'b1});
    wb(1'b1, fcs_pkg::REG_CTRL, 32'h0000_0010);
    wb(1'b0, fcs_pkg::REG_STAT, Z);
    chk("abort idle", Z, {31'h0000_0000, q[fcs_pkg::STAT_BUSY]});
    wait_st(fcs_pkg::STAT_RB, 1'b1);
    chk("flags cleared", Z, {24'h00_0000, q[15:8]});
    wb(1'b1, fcs_pkg::REG_CTRL, Z);
    wait_st(fcs_pkg::STAT_AWAKE, 1'b1);
    rd_arr(19'h1_23c3);
    flags(8'h80, 8'hff);
    $display("test abort done");
    busy();
    wait_st(fcs_pkg::STAT_RB, 1'b1);
    flags(8'h90, 8'hff);
    op(fcs_pkg::OP_READ_ARRAY);
    rd_arr(19'h7_ff5a);
    $display("test reissue done");
    end_sim();
  end
endmodule
